/* File: design/pbcs_top.v */
// basic control, status and identifier registers of the phy, reached
// over the serial management link (mdc sampled, mdio three-signal pin)
// assumes mdc is far slower than clk; status inputs are on clk already
//
// Notes on behaviour
// - control reset bit self-clears, resets device
// - bit fourteen enables loopback, default zero
// - bit thirteen selects 100 or 10 megabit
// - bit twelve enables auto-negotiation, default one
// - bit eleven selects low-power mode, default zero
// - bit ten isolates rmii data interface
// - restart negotiation bit self-clears after pulse
// - bit eight selects full duplex, default one
// - bits six to zero zero; seven spare
// - status bit fifteen always reads zero
// - bits fourteen-eleven one, ten-seven zero
// - status bit six zero, preamble required
// - negotiation complete latches high until read
// - remote fault latches high until read
// - link status latches low until read
// - jabber detect latches high until read
// - status bits three and zero read one
// - strap address zero tri-states rmii interface
`timescale 1ns/1ps
`include "pbcs_map_regs.vh"

module pbcs_top #(
  parameter [15:0] ID_HIGH = 16'h0a5c // identifier code, value arbitrary
) (
  input wire clk, // 10 MHz block clock
  input wire resetn, // asynchronous reset, active low
  input wire [4:0] phy_addr_strap, // static management address strap
  input wire mdc, // management clock from the controller
  input wire mdio_in, // management data, pin level
  output wire mdio_out, // management data driven by the device
  output wire mdio_oe, // high while the device drives mdio
  input wire link_live, // live link valid indication
  input wire jabber_live, // live jabber detected indication
  input wire remote_fault_live, // live remote fault indication
  input wire an_done_live, // live negotiation complete indication
  output wire loopback_en, // loopback mode selected
  output wire speed_100, // 100 megabit selected, else 10
  output wire an_enable, // automatic negotiation enabled
  output wire low_power, // low-power mode selected
  output wire isolate, // device isolated from rmii data
  output wire duplex_full, // full duplex selected, else half
  output wire spare_ctrl, // spare read-write control bit
  output wire an_restart, // one-cycle negotiation restart pulse
  output wire soft_reset, // one-cycle device reset pulse
  output wire rmii_hiz // rmii data outputs to high impedance
);

  // frame states
  localparam [2:0] ST_PRE = 3'h0; // counting preamble ones
  localparam [2:0] ST_START = 3'h1; // second start bit
  localparam [2:0] ST_OP = 3'h2; // two opcode bits
  localparam [2:0] ST_ADDR = 3'h3; // phy and register address
  localparam [2:0] ST_TA = 3'h4; // turnaround
  localparam [2:0] ST_DATA = 3'h5; // sixteen data bits

  // reset release
  reg rst_a_reg; // first reset stage
  reg rst_n_reg; // synchronised reset used by the design

  // strap capture
  reg [4:0] strap_reg; // captured management address
  reg strap_done_reg; // strap has been captured

  // synchronised link pins
  wire mdc_rise; // one-cycle pulse per mdc rising edge
  wire mdio_level; // filtered mdio level

  // frame engine state
  reg [2:0] st_reg; // frame state
  reg [5:0] cnt_reg; // bit counter within a field
  reg [1:0] op_reg; // opcode of the frame
  reg [9:0] addr_reg; // phy address then register address
  reg [15:0] sh_reg; // data shift register, both directions
  reg hit_reg; // frame addressed to this device
  reg rd_act_reg; // device is driving read data
  reg out_reg; // mdio output level
  reg oe_reg; // mdio output enable
  reg wr_stb_reg; // one-cycle register write strobe
  reg [4:0] wr_addr_reg; // write register address
  reg [15:0] wr_data_reg; // write data

  // control register fields
  reg loopback_reg; // loopback selected
  reg speed_reg; // 100 megabit selected
  reg an_en_reg; // negotiation enabled
  reg low_power_reg; // low-power mode
  reg isolate_reg; // isolate from rmii
  reg duplex_reg; // full duplex
  reg spare_reg; // spare bit seven
  reg reset_bit_reg; // reset bit, self clearing
  reg restart_bit_reg; // restart bit, self clearing
  reg soft_reset_reg; // reset pulse out
  reg an_restart_reg; // restart pulse out

  // latched status fields
  reg an_done_lat_reg; // latches high
  reg rf_lat_reg; // latches high
  reg link_lat_reg; // latches low
  reg jab_lat_reg; // latches high

  wire frame_bit; // mdio value sampled at this mdc rise
  wire ctrl_write; // write to the control register
  wire stat_read; // read of the status register
  wire rd_take; // read word taken in this cycle
  wire [15:0] ctrl_value; // control register as read
  wire [15:0] stat_value; // status register as read

  // register read decode; unmapped addresses read zero
  function [15:0] read_mux;
    input [4:0] addr;
    input [15:0] ctrl;
    input [15:0] stat;
    begin
      case (addr)
        `PBCS_ADDR_CONTROL: read_mux = ctrl;
        `PBCS_ADDR_STATUS: read_mux = stat;
        `PBCS_ADDR_ID_HIGH: read_mux = ID_HIGH;
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_a_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_n_reg <= rst_a_reg;
    end
  end

  // strap caught once, on the first cycle after reset release
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      strap_reg <= 5'h00;
      strap_done_reg <= 1'b0;
    end else if (!strap_done_reg) begin
      strap_reg <= phy_addr_strap;
      strap_done_reg <= 1'b1;
    end
  end

  // mdc and mdio pass the three-stage filter
  pbcs_sync u_mdc_sync (
    .clk(clk),
    .rst_n(rst_n_reg),
    .pin_in(mdc),
    .level_out(),
    .rise_out(mdc_rise)
  );

  pbcs_sync u_mdio_sync (
    .clk(clk),
    .rst_n(rst_n_reg),
    .pin_in(mdio_in),
    .level_out(mdio_level),
    .rise_out()
  );

  assign frame_bit = mdio_level;

  // frame engine: one step per mdc rising edge
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      st_reg <= ST_PRE;
      cnt_reg <= 6'h00;
      op_reg <= 2'h0;
      addr_reg <= 10'h000;
      sh_reg <= 16'h0000;
      hit_reg <= 1'b0;
      rd_act_reg <= 1'b0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_addr_reg <= 5'h00;
      wr_data_reg <= 16'h0000;
    end else begin
      wr_stb_reg <= 1'b0;
      if (mdc_rise) begin
        case (st_reg)
          // need the full run of ones before a start zero
          ST_PRE: begin
            if (frame_bit) begin
              if (cnt_reg != `PBCS_PREAMBLE_LEN) begin
                cnt_reg <= cnt_reg + 6'h01;
              end
            end else if (cnt_reg == `PBCS_PREAMBLE_LEN) begin
              st_reg <= ST_START;
              cnt_reg <= 6'h00;
            end else begin
              cnt_reg <= 6'h00;
            end
          end
          // start pattern must end in a one
          ST_START: begin
            cnt_reg <= 6'h00;
            if (frame_bit) begin
              st_reg <= ST_OP;
            end else begin
              st_reg <= ST_PRE;
            end
          end
          // opcode, msb first
          ST_OP: begin
            op_reg <= {op_reg[0], frame_bit};
            if (cnt_reg[0]) begin
              st_reg <= ST_ADDR;
              cnt_reg <= 6'h00;
            end else begin
              cnt_reg <= 6'h01;
            end
          end
          // phy address then register address
          ST_ADDR: begin
            addr_reg <= {addr_reg[8:0], frame_bit};
            if (cnt_reg[3:0] == `PBCS_ADDR_BITS_LAST) begin
              st_reg <= ST_TA;
              cnt_reg <= 6'h00;
              hit_reg <= (addr_reg[8:4] == strap_reg);
            end else begin
              cnt_reg <= cnt_reg + 6'h01;
            end
          end
          // turnaround: take the read word, drive zero, then msb
          ST_TA: begin
            if (cnt_reg == 6'h00) begin
              cnt_reg <= 6'h01;
              if (hit_reg && op_reg == `PBCS_OP_READ) begin
                sh_reg <= read_mux(addr_reg[4:0], ctrl_value,
                  stat_value);
                rd_act_reg <= 1'b1;
                out_reg <= 1'b0;
                oe_reg <= 1'b1;
              end
            end else begin
              st_reg <= ST_DATA;
              cnt_reg <= 6'h00;
              if (rd_act_reg) begin
                out_reg <= sh_reg[15];
                sh_reg <= {sh_reg[14:0], 1'b0};
              end
            end
          end
          // data bits; writes shift in, reads shift out
          ST_DATA: begin
            if (rd_act_reg) begin
              out_reg <= sh_reg[15];
              sh_reg <= {sh_reg[14:0], 1'b0};
            end else begin
              sh_reg <= {sh_reg[14:0], frame_bit};
            end
            if (cnt_reg[3:0] == `PBCS_DATA_BITS_LAST) begin
              // frame over, release the pin, wait for a new preamble
              oe_reg <= 1'b0;
              out_reg <= 1'b0;
              rd_act_reg <= 1'b0;
              st_reg <= ST_PRE;
              cnt_reg <= 6'h00;
              if (hit_reg && op_reg == `PBCS_OP_WRITE) begin
                wr_stb_reg <= 1'b1;
                wr_addr_reg <= addr_reg[4:0];
                wr_data_reg <= {sh_reg[14:0], frame_bit};
              end
            end else begin
              cnt_reg <= cnt_reg + 6'h01;
            end
          end
          default: begin
            st_reg <= ST_PRE;
            cnt_reg <= 6'h00;
          end
        endcase
      end
    end
  end

  assign mdio_out = out_reg;
  assign mdio_oe = oe_reg;

  // register access strobes; identifier and unmapped writes are dropped
  assign ctrl_write = wr_stb_reg && (wr_addr_reg == `PBCS_ADDR_CONTROL);
  // word taken at the first turnaround rise; a status read loads the live
  // values into the latches in that same cycle, so an event in that cycle is kept
  assign rd_take = mdc_rise && (st_reg == ST_TA) && (cnt_reg == 6'h00)
    && hit_reg && (op_reg == `PBCS_OP_READ);
  assign stat_read = rd_take && (addr_reg[4:0] == `PBCS_ADDR_STATUS);

  // control register; reserved bits six to zero read zero
  assign ctrl_value = {reset_bit_reg, loopback_reg, speed_reg, an_en_reg,
    low_power_reg, isolate_reg, restart_bit_reg, duplex_reg, spare_reg,
    7'h00};

  // status register: constant abilities plus latched indications
  assign stat_value = `PBCS_STAT_CONST
    | ({15'h0000, an_done_lat_reg} << `PBCS_STAT_AN_DONE)
    | ({15'h0000, rf_lat_reg} << `PBCS_STAT_REMOTE_FAULT)
    | ({15'h0000, link_lat_reg} << `PBCS_STAT_LINK)
    | ({15'h0000, jab_lat_reg} << `PBCS_STAT_JABBER);

  // control fields, write handling and self-clearing bits
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      loopback_reg <= 1'b0;
      speed_reg <= 1'b1;
      an_en_reg <= 1'b1;
      low_power_reg <= 1'b0;
      isolate_reg <= 1'b0;
      duplex_reg <= 1'b1;
      spare_reg <= 1'b0;
      reset_bit_reg <= 1'b0;
      restart_bit_reg <= 1'b0;
      soft_reset_reg <= 1'b0;
      an_restart_reg <= 1'b0;
    end else begin
      soft_reset_reg <= 1'b0;
      an_restart_reg <= 1'b0;
      restart_bit_reg <= 1'b0;
      if (!strap_done_reg) begin
        // isolate default follows the address strap
        isolate_reg <= (phy_addr_strap == 5'h00);
      end else if (reset_bit_reg) begin
        // one cycle later all fields take defaults, bit reads zero
        loopback_reg <= 1'b0;
        speed_reg <= 1'b1;
        an_en_reg <= 1'b1;
        low_power_reg <= 1'b0;
        isolate_reg <= (strap_reg == 5'h00);
        duplex_reg <= 1'b1;
        spare_reg <= 1'b0;
        reset_bit_reg <= 1'b0;
      end else if (ctrl_write) begin
        loopback_reg <= wr_data_reg[`PBCS_CTL_LOOPBACK];
        speed_reg <= wr_data_reg[`PBCS_CTL_SPEED];
        an_en_reg <= wr_data_reg[`PBCS_CTL_AN_EN];
        low_power_reg <= wr_data_reg[`PBCS_CTL_LOW_POWER];
        isolate_reg <= wr_data_reg[`PBCS_CTL_ISOLATE];
        duplex_reg <= wr_data_reg[`PBCS_CTL_DUPLEX];
        spare_reg <= wr_data_reg[`PBCS_CTL_SPARE];
        // writing one to reset starts a device reset; zero does nothing
        if (wr_data_reg[`PBCS_CTL_RESET]) begin
          reset_bit_reg <= 1'b1;
          soft_reset_reg <= 1'b1;
        end
        // writing one to restart gives one restart pulse
        if (wr_data_reg[`PBCS_CTL_AN_RESTART]) begin
          restart_bit_reg <= 1'b1;
          an_restart_reg <= 1'b1;
        end
      end
    end
  end

  // latched status; an event in the read cycle is kept (set wins)
  always @(posedge clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      an_done_lat_reg <= 1'b0;
      rf_lat_reg <= 1'b0;
      link_lat_reg <= 1'b0;
      jab_lat_reg <= 1'b0;
    end else if (reset_bit_reg) begin
      an_done_lat_reg <= 1'b0;
      rf_lat_reg <= 1'b0;
      link_lat_reg <= 1'b0;
      jab_lat_reg <= 1'b0;
    end else if (stat_read) begin
      // a read returns each bit to its live value
      an_done_lat_reg <= an_done_live;
      rf_lat_reg <= remote_fault_live;
      link_lat_reg <= link_live;
      jab_lat_reg <= jabber_live;
    end else begin
      an_done_lat_reg <= an_done_lat_reg | an_done_live;
      rf_lat_reg <= rf_lat_reg | remote_fault_live;
      link_lat_reg <= link_lat_reg & link_live;
      jab_lat_reg <= jab_lat_reg | jabber_live;
    end
  end

  // control outputs straight from the register fields
  assign loopback_en = loopback_reg;
  assign speed_100 = speed_reg;
  assign an_enable = an_en_reg;
  assign low_power = low_power_reg;
  assign isolate = isolate_reg;
  assign duplex_full = duplex_reg;
  assign spare_ctrl = spare_reg;
  assign an_restart = an_restart_reg;
  assign soft_reset = soft_reset_reg;
  assign rmii_hiz = isolate_reg;

endmodule

/* File: design/pbcs_map_regs.vh */
// register map, field positions and frame constants of the management bank
// assumes a 16-bit management data word and 5-bit register addresses
`ifndef PBCS_MAP_REGS_VH
`define PBCS_MAP_REGS_VH

// register addresses within the management space
`define PBCS_ADDR_CONTROL 5'h00
`define PBCS_ADDR_STATUS 5'h01
`define PBCS_ADDR_ID_HIGH 5'h02

// control register field positions
`define PBCS_CTL_RESET 15
`define PBCS_CTL_LOOPBACK 14
`define PBCS_CTL_SPEED 13
`define PBCS_CTL_AN_EN 12
`define PBCS_CTL_LOW_POWER 11
`define PBCS_CTL_ISOLATE 10
`define PBCS_CTL_AN_RESTART 9
`define PBCS_CTL_DUPLEX 8
`define PBCS_CTL_SPARE 7

// control register defaults (isolate comes from the address strap)
`define PBCS_CTL_DEFAULT 16'h3100

// status register constant part and latched field positions
`define PBCS_STAT_CONST 16'h7809
`define PBCS_STAT_AN_DONE 5
`define PBCS_STAT_REMOTE_FAULT 4
`define PBCS_STAT_LINK 2
`define PBCS_STAT_JABBER 1

// management frame constants
`define PBCS_PREAMBLE_LEN 6'h20
`define PBCS_OP_READ 2'h2
`define PBCS_OP_WRITE 2'h1
`define PBCS_ADDR_BITS_LAST 4'h9
`define PBCS_DATA_BITS_LAST 4'hf

`endif

/* File: design/pbcs_sync.v */
// three-stage synchroniser with agreement filter and rising-edge pulse
// assumes the input is asynchronous to clk and slow against it
`timescale 1ns/1ps

module pbcs_sync (
  input wire clk, // block clock
  input wire rst_n, // synchronised reset, active low
  input wire pin_in, // asynchronous input
  output reg level_out, // filtered level
  output reg rise_out // one-cycle pulse on a filtered rise
);

  reg s1_reg; // first stage, read only by the second
  reg s2_reg; // second stage
  reg s3_reg; // third stage

  // shift chain; level follows once stages two and three agree
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_out <= 1'b0;
      rise_out <= 1'b0;
    end else begin
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      rise_out <= 1'b0;
      if (s2_reg == s3_reg) begin
        level_out <= s3_reg;
        // rise seen once, on the cycle the level turns high
        if (s3_reg && !level_out) begin
          rise_out <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: sim/pbcs_top_properties.sv */
// pin-level assertions for the management register bank
// assumes the top module's ports and a slow management clock
`timescale 1ns/1ps

module pbcs_top_properties (
  input wire clk, // block clock
  input wire resetn, // reset, active low
  input wire [4:0] phy_addr_strap, // address strap
  input wire mdc, // management clock pin
  input wire mdio_in, // mdio line level
  input wire mdio_out, // level driven by the bank
  input wire mdio_oe, // bank drives mdio
  input wire link_live, // live link
  input wire jabber_live, // live jabber
  input wire remote_fault_live, // live remote fault
  input wire an_done_live, // live negotiation done
  input wire loopback_en, // loopback field
  input wire speed_100, // speed field
  input wire an_enable, // negotiation enable
  input wire low_power, // low-power field
  input wire isolate, // isolate field
  input wire duplex_full, // duplex field
  input wire spare_ctrl, // spare field
  input wire an_restart, // restart pulse
  input wire soft_reset, // reset pulse
  input wire rmii_hiz // rmii tri-state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  reg mdc_q; // mdc seen last cycle
  reg [3:0] since_rise; // clocks since mdc rose, saturating
  // counts clocks from each mdc rise seen on clk
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mdc_q <= 1'b0;
      since_rise <= 4'hf;
    end else begin
      mdc_q <= mdc;
      if (mdc && !mdc_q) begin
        since_rise <= 4'h0; // fresh rise
      end else if (since_rise != 4'hf) begin
        since_rise <= since_rise + 4'h1;
      end
    end
  end
  a_hiz_follows: assert property (rmii_hiz == isolate)
    else $error("rmii tri-state differs from isolate");
  a_restart_pulse: assert property (an_restart |=> !an_restart)
    else $error("restart pulse longer than one cycle");
  a_reset_pulse: assert property (soft_reset |=> !soft_reset)
    else $error("reset pulse longer than one cycle");
  a_soft_defaults: assert property (soft_reset |-> ##2 (speed_100
    && an_enable && duplex_full && !loopback_en && !low_power
    && !spare_ctrl)) else $error("fields not default after reset");
  a_soft_isolate: assert property (soft_reset |-> ##2
    (isolate == (phy_addr_strap == 5'h00)))
    else $error("isolate not strap value after reset");
  a_strap_isolate: assert property ($rose(resetn) |-> ##4
    (isolate == (phy_addr_strap == 5'h00)))
    else $error("isolate not strap value after release");
  a_reset_values: assert property ($rose(resetn) |-> (speed_100
    && an_enable && duplex_full && !loopback_en && !mdio_oe))
    else $error("outputs not at reset values");
  a_drive_timing: assert property (($rose(mdio_oe) || $fell(mdio_oe))
    |-> (since_rise >= 4'h1 && since_rise <= 4'h7))
    else $error("mdio drive changed away from an mdc rise");
  a_drive_hold: assert property ($rose(mdio_oe) |->
    !mdio_out ##1 mdio_oe [*8]) else $error("turnaround drive wrong");
  c_soft: cover property (soft_reset);
  c_restart: cover property (an_restart);
  c_answer: cover property ($rose(mdio_oe));
endmodule

bind pbcs_top pbcs_top_properties i_props (.clk(clk), .resetn(resetn),
  .phy_addr_strap(phy_addr_strap), .mdc(mdc), .mdio_in(mdio_in),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .link_live(link_live),
  .jabber_live(jabber_live), .remote_fault_live(remote_fault_live),
  .an_done_live(an_done_live), .loopback_en(loopback_en),
  .speed_100(speed_100), .an_enable(an_enable), .low_power(low_power),
  .isolate(isolate), .duplex_full(duplex_full), .spare_ctrl(spare_ctrl),
  .an_restart(an_restart), .soft_reset(soft_reset), .rmii_hiz(rmii_hiz));

/* File: sim/pbcs_sta_model.sv */
// station manager model: makes mdc and frames on mdio
// assumes a pull-up on mdio; mdc stands still between frames
`timescale 1ns/1ps

module pbcs_sta_model #(
  parameter int HALF = 400 // half mdc period in ns
) (
  input wire mdio_level, // resolved mdio line
  output logic mdc = 1'b0, // management clock
  output logic sta_oe = 1'b0, // model drives mdio
  output logic sta_out = 1'b1 // level the model drives
);
  // one frame: npre ones, start, op, addresses, turnaround, data
  task automatic frame(input int npre, input [1:0] op, input [4:0] pa,
      input [4:0] ra, input [15:0] wd, output [15:0] rd);
    logic [31:0] hdr;
    int k;
    hdr = {2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int j = 0; j < npre + 32; j++) begin
      k = j - npre;
      mdc = 1'b0;
      sta_oe = (k < 14) || (op == 2'b01); // released for read turnaround
      sta_out = (k < 0) ? 1'b1 : hdr[31 - k];
      #HALF;
      mdc = 1'b1;
      if (k >= 16) begin
        rd = {rd[14:0], mdio_level}; // read data msb first
      end
      #HALF;
    end
    mdc = 1'b0;
    sta_oe = 1'b0;
  endtask
endmodule

/* File: sim/pbcs_top_tb.sv */
// self-checking bench for the management register bank
// assumes the station model drives mdc and mdio with a pull-up
`timescale 1ns/1ps

module pbcs_top_tb;
  localparam [15:0] ID_VAL = 16'h1c3b; // arbitrary identifier value
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] strap = 5'h00;
  logic link_live = 1'b1;
  logic jab_live = 1'b0;
  logic rf_live = 1'b0;
  logic an_live = 1'b0;
  logic [15:0] rd, w, c;
  logic [3:0] m;
  wire mdc, mdio_w, mdio_out, mdio_oe, sta_oe, sta_out;
  wire lpb, spd, ane, lowp, iso, dpx, spare, rst_p, rs_p, hiz;
  int bad_count = 0;
  int n_tests = 0;
  int n_restart = 0;
  int n_sreset = 0;
  // line level: bank, else model, else pull-up
  assign mdio_w = mdio_oe ? mdio_out : (sta_oe ? sta_out : 1'b1);
  always #50 clk = ~clk;
  pbcs_top #(.ID_HIGH(ID_VAL)) i_dut (.clk(clk), .resetn(resetn),
    .phy_addr_strap(strap), .mdc(mdc), .mdio_in(mdio_w),
    .mdio_out(mdio_out), .mdio_oe(mdio_oe), .link_live(link_live),
    .jabber_live(jab_live), .remote_fault_live(rf_live),
    .an_done_live(an_live), .loopback_en(lpb), .speed_100(spd),
    .an_enable(ane), .low_power(lowp), .isolate(iso),
    .duplex_full(dpx), .spare_ctrl(spare), .an_restart(rs_p),
    .soft_reset(rst_p), .rmii_hiz(hiz));
  pbcs_sta_model i_sta (.mdio_level(mdio_w), .mdc(mdc),
    .sta_oe(sta_oe), .sta_out(sta_out));
  // counts the one-cycle pulses
  always @(posedge clk) begin
    if (rs_p === 1'b1) n_restart++;
    if (rst_p === 1'b1) n_sreset++;
  end
  task check(input string what, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task xfer(input int npre, input [1:0] op, input [4:0] pa, ra,
      input [15:0] wd);
    @(posedge clk);
    #5;
    i_sta.frame(npre, op, pa, ra, wd, rd);
    repeat (8) @(posedge clk);
  endtask
  task rd_reg(input [4:0] ra);
    xfer(32, 2'b10, strap, ra, 16'h0000);
  endtask
  task wr_reg(input [4:0] ra, input [15:0] d);
    xfer(32, 2'b01, strap, ra, d);
  endtask
  // status word after one pulse: an, fault, link loss, jabber
  function automatic [15:0] stat_exp(input [3:0] e);
    return 16'h7809 | {10'h0, e[3], e[2], 1'b0, ~e[1], e[0], 1'b0};
  endfunction
  function automatic [15:0] outs();
    return {9'h0, lpb, spd, ane, lowp, iso, dpx, spare};
  endfunction
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // watchdog well beyond the frames needed
  initial begin
    #6000000;
    bad_count++;
    report_and_stop;
  end
  initial begin
    void'($urandom(32'h865d));
    strap = 5'h01 + 5'($urandom % 31); // any nonzero address
    repeat (5) @(posedge clk);
    #5 resetn = 1'b1;
    repeat (6) @(posedge clk);
    rd_reg(5'h00);
    check("control", rd, 16'h3100);
    rd_reg(5'h01);
    check("status", rd, 16'h7809);
    wr_reg(5'h02, ~ID_VAL);
    rd_reg(5'h02);
    check("ident", rd, ID_VAL);
    rd_reg(5'h09);
    check("unmapped", rd, 16'h0000);
    wr_reg(5'h01, 16'h0000);
    rd_reg(5'h01);
    check("status", rd, 16'h780d);
    $display("test defaults done");
    for (int i = 0; i < 6; i++) begin
      m = (i == 0) ? 4'hf : 4'($urandom);
      @(posedge clk);
      #5 {an_live, rf_live, jab_live, link_live} = {m[3:2], m[0], ~m[1]};
      @(posedge clk);
      #5 {an_live, rf_live, jab_live, link_live} = 4'h1;
      rd_reg(5'h01);
      check("status", rd, stat_exp(m));
      rd_reg(5'h01);
      check("status", rd, 16'h780d);
    end
    $display("test latched status done");
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 16'h7fff : 16'($urandom);
      w[15] = 1'b0;
      c = 16'(n_restart);
      wr_reg(5'h00, w);
      check("restart", 16'(n_restart) - c, {15'h0, w[9]});
      check("fields", outs(), {9'h0, w[14:10], w[8:7]});
      check("hiz", {15'h0, hiz}, {15'h0, w[10]});
      rd_reg(5'h00);
      check("control", rd, w & 16'h7d80);
    end
    $display("test control writes done");
    wr_reg(5'h00, 16'hc680);
    check("sreset", 16'(n_sreset), 16'h0001);
    rd_reg(5'h00);
    check("control", rd, 16'h3100);
    rd_reg(5'h01);
    check("status", rd, 16'h7809);
    $display("test soft reset done");
    wr_reg(5'h09, 16'h0000);
    xfer(31, 2'b10, strap, 5'h00, 16'h0000);
    check("short", rd, 16'hffff);
    xfer(32, 2'b10, strap ^ 5'h01, 5'h00, 16'h0000);
    check("phyad", rd, 16'hffff);
    xfer(32, 2'b01, strap ^ 5'h01, 5'h00, 16'h0000);
    rd_reg(5'h00);
    check("control", rd, 16'h3100);
    $display("test refused frames done");
    @(posedge clk);
    #5 resetn = 1'b0;
    strap = 5'h00;
    repeat (5) @(posedge clk);
    #5 resetn = 1'b1;
    repeat (6) @(posedge clk);
    check("hiz", {15'h0, hiz}, 16'h0001);
    rd_reg(5'h00);
    check("control", rd, 16'h3500);
    wr_reg(5'h00, 16'h3100);
    check("hiz", {15'h0, hiz}, 16'h0000);
    $display("test strap zero done");
    report_and_stop;
  end
endmodule
